// ===== design/ucv_pkg.sv
package ucv_pkg;
  // Immediate register addresses (6-bit ULPI address space)
  localparam logic [5:0] ADDR_EVENT_LATCH = 6'h21;
  localparam logic [5:0] ADDR_SIG_COMP    = 6'h31;
  localparam logic [5:0] ADDR_CHG_DETECT  = 6'h32;
  localparam logic [5:0] VENDOR_LO        = 6'h30;
  localparam logic [5:0] VENDOR_HI        = 6'h3F;

  // TXCMD command codes in bits 7:6
  localparam logic [1:0] CMD_REG_WRITE = 2'h2;
  localparam logic [1:0] CMD_REG_READ  = 2'h3;

  // Event latch bit positions
  localparam int LAT_ID_FLOAT = 0;
  localparam int LAT_COMP     = 1;
  localparam int LAT_RES_CONV = 3;

  // Writable masks and reset values
  localparam logic [7:0] SIG_COMP_MASK  = 8'h73;
  localparam logic [7:0] SIG_COMP_RESET = 8'h00;
  localparam logic [7:0] CHG_CTRL_MASK  = 8'h0F;
  localparam logic [7:0] CHG_CTRL_RESET = 8'h00;
  localparam logic [3:0] LATCH_RESET    = 4'h0;

  // Charger detection field positions
  localparam int CHG_VSRC    = 0;
  localparam int CHG_ISINK   = 1;
  localparam int CHG_CONTACT = 2;
  localparam int CHG_HOST    = 3;
  localparam int CHG_STATUS  = 4;

  // Compensation fields
  localparam int SQ_LSB    = 0;
  localparam int BOOST_LSB = 4;

  // RXCMD layout
  localparam int         RXCMD_ALT_INT = 7;
  localparam logic [1:0] LINE_SE0      = 2'h0;

  // Resistor conversion time
  localparam int CLK_PERIOD_NS = 100;
  localparam int RES_CONV_US   = 282;
  localparam int RES_CONV_CYC  = (RES_CONV_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WR_ACK, ST_WR_CAP, ST_WR_STP,
    ST_RD_ACK, ST_RD_TURN, ST_RD_DATA,
    ST_RX_TURN, ST_RX_DATA
  } ucv_state_t;
endpackage

// ===== design/ucv_regs.sv
`timescale 1ns/1ns
module ucv_regs (
  // System
  input  wire logic       MCLK_I,
  input  wire logic       RST_I,
  // ULPI
  input  wire logic       ULPI_CLK_I,
  input  wire logic [7:0] ULPI_DATA_I,
  output logic      [7:0] ULPI_DATA_O,
  output logic            ULPI_DATA_OE_N_O,
  output logic            ULPI_DIR_O,
  output logic            ULPI_NXT_O,
  input  wire logic       ULPI_STP_I,
  // Analog status
  input  wire logic       ID_FLOAT_I,
  input  wire logic       COMP_DP_I,
  input  wire logic       COMP_DM_I,
  input  wire logic [1:0] LINESTATE_I,
  // Enables held in other registers
  input  wire logic       ID_FLOAT_RISE_ENABLE_I,
  input  wire logic       ID_FLOAT_FALL_ENABLE_I,
  input  wire logic       COMPARATOR_EVENT_ENABLE_I,
  input  wire logic       RESISTOR_CONV_EVENT_ENABLE_I,
  input  wire logic       RESISTOR_CONV_START_I,
  // Analog controls
  output logic      [1:0] SQUELCH_THRESHOLD_SELECT_O,
  output logic      [2:0] TX_AMPLITUDE_BOOST_O,
  output logic            VSRC_DP_O,
  output logic            VSRC_DM_O,
  output logic            ISINK_DP_O,
  output logic            ISINK_DM_O,
  output logic            CONTACT_DP_O,
  output logic            CONTACT_DM_O,
  output logic            RESISTOR_CONV_COMPLETE_O
);

  typedef struct packed {
    logic [1:0]  clk_s;
    logic [15:0] dat_s;
    logic [1:0]  stp_s;
    logic [1:0]  idf_s;
    logic [1:0]  cdp_s;
    logic [1:0]  cdm_s;
    logic [3:0]  ls_s;
    logic        idf_q;
    logic        comp_q;
    logic        done_q;
    logic        clk_q;
    ucv_pkg::ucv_state_t st;
    logic [5:0]  addr;
    logic [3:0]  latch;
    logic        alt_pend;
    logic [7:0]  comp_reg;
    logic [7:0]  chg_reg;
    logic [7:0]  dout;
    logic        oe_n;
    logic        dir;
    logic        nxt;
    logic [11:0] conv_cnt;
    logic        conv_busy;
    logic        conv_done;
  } ucv_st_t;

  ucv_st_t s_r;
  ucv_st_t s_nxt;

  logic [7:0] din;
  logic       stp;
  logic       ulpi_rise;
  logic       host;
  logic       comp_stat;
  logic       id_float;
  logic [3:0] ev;
  logic [7:0] rd_val;

  always_comb begin
    din       = s_r.dat_s[15:8];
    stp       = s_r.stp_s[1];
    id_float  = s_r.idf_s[1];
    ulpi_rise = s_r.clk_s[1] & ~s_r.clk_q;
    host      = s_r.chg_reg[ucv_pkg::CHG_HOST];
    // Comparator follows the swapped line in host-port mode
    comp_stat = s_r.chg_reg[ucv_pkg::CHG_ISINK] &
                (host ? s_r.cdm_s[1] : s_r.cdp_s[1]) &
                (s_r.ls_s[3:2] == ucv_pkg::LINE_SE0);

    ev = 4'h0;
    ev[ucv_pkg::LAT_ID_FLOAT] =
      (id_float & ~s_r.idf_q & ID_FLOAT_RISE_ENABLE_I) |
      (~id_float & s_r.idf_q & ID_FLOAT_FALL_ENABLE_I);
    ev[ucv_pkg::LAT_COMP] =
      (comp_stat ^ s_r.comp_q) & COMPARATOR_EVENT_ENABLE_I;
    ev[ucv_pkg::LAT_RES_CONV] =
      s_r.conv_done & ~s_r.done_q & RESISTOR_CONV_EVENT_ENABLE_I;

    // Unmapped addresses read as zero
    rd_val = 8'h00;
    if (s_r.addr == ucv_pkg::ADDR_EVENT_LATCH) begin
      rd_val = {4'h0, s_r.latch & 4'hB};
    end else if (s_r.addr == ucv_pkg::ADDR_SIG_COMP) begin
      rd_val = s_r.comp_reg & ucv_pkg::SIG_COMP_MASK;
    end else if (s_r.addr == ucv_pkg::ADDR_CHG_DETECT) begin
      rd_val = (s_r.chg_reg & ucv_pkg::CHG_CTRL_MASK) |
               ({7'h00, comp_stat} << ucv_pkg::CHG_STATUS);
    end

    s_nxt        = s_r;
    s_nxt.clk_s  = {s_r.clk_s[0], ULPI_CLK_I};
    s_nxt.dat_s  = {s_r.dat_s[7:0], ULPI_DATA_I};
    s_nxt.stp_s  = {s_r.stp_s[0], ULPI_STP_I};
    s_nxt.idf_s  = {s_r.idf_s[0], ID_FLOAT_I};
    s_nxt.cdp_s  = {s_r.cdp_s[0], COMP_DP_I};
    s_nxt.cdm_s  = {s_r.cdm_s[0], COMP_DM_I};
    s_nxt.ls_s   = {s_r.ls_s[1:0], LINESTATE_I};
    s_nxt.clk_q  = s_r.clk_s[1];
    s_nxt.idf_q  = id_float;
    s_nxt.comp_q = comp_stat;
    s_nxt.done_q = s_r.conv_done;

    // Conversion timer; a new start restarts it
    if (RESISTOR_CONV_START_I) begin
      s_nxt.conv_busy = 1'b1;
      s_nxt.conv_done = 1'b0;
      s_nxt.conv_cnt  = 12'(ucv_pkg::RES_CONV_CYC - 1);
    end else if (s_r.conv_busy) begin
      if (s_r.conv_cnt == 12'h000) begin
        s_nxt.conv_busy = 1'b0;
        s_nxt.conv_done = 1'b1;
      end else begin
        s_nxt.conv_cnt = s_r.conv_cnt - 12'h001;
      end
    end

    if (|ev) begin
      s_nxt.alt_pend = 1'b1;
    end

    // Bus steps once per ULPI rising edge
    if (ulpi_rise) begin
      case (s_r.st)
        ucv_pkg::ST_IDLE: begin
          if (din[7:6] == ucv_pkg::CMD_REG_WRITE) begin
            s_nxt.addr = din[5:0];
            s_nxt.nxt  = 1'b1;
            s_nxt.st   = ucv_pkg::ST_WR_ACK;
          end else if (din[7:6] == ucv_pkg::CMD_REG_READ) begin
            s_nxt.addr = din[5:0];
            s_nxt.nxt  = 1'b1;
            s_nxt.st   = ucv_pkg::ST_RD_ACK;
          end else if (s_r.alt_pend) begin
            s_nxt.dir = 1'b1;
            s_nxt.st  = ucv_pkg::ST_RX_TURN;
          end
        end
        ucv_pkg::ST_WR_ACK: begin
          s_nxt.st = ucv_pkg::ST_WR_CAP;
        end
        ucv_pkg::ST_WR_CAP: begin
          s_nxt.nxt = 1'b0;
          s_nxt.st  = ucv_pkg::ST_WR_STP;
          // Decode limited to ADDR_SIG_COMP and ADDR_CHG_DETECT; latch writes are ignored
          if (s_r.addr == ucv_pkg::ADDR_SIG_COMP) begin
            s_nxt.comp_reg = din & ucv_pkg::SIG_COMP_MASK;
          end else if (s_r.addr == ucv_pkg::ADDR_CHG_DETECT) begin
            s_nxt.chg_reg = din & ucv_pkg::CHG_CTRL_MASK;
          end
        end
        ucv_pkg::ST_WR_STP: begin
          if (stp) begin
            s_nxt.st = ucv_pkg::ST_IDLE;
          end
        end
        ucv_pkg::ST_RD_ACK: begin
          s_nxt.nxt  = 1'b0;
          s_nxt.dir  = 1'b1;
          s_nxt.dout = rd_val;
          if (s_r.addr == ucv_pkg::ADDR_EVENT_LATCH) begin
            // Only returned bits clear; a new event still sets
            s_nxt.latch = s_r.latch & ~rd_val[3:0];
          end
          s_nxt.st = ucv_pkg::ST_RD_TURN;
        end
        ucv_pkg::ST_RD_TURN: begin
          s_nxt.oe_n = 1'b0;
          s_nxt.st   = ucv_pkg::ST_RD_DATA;
        end
        ucv_pkg::ST_RD_DATA: begin
          s_nxt.oe_n = 1'b1;
          s_nxt.dir  = 1'b0;
          s_nxt.st   = ucv_pkg::ST_IDLE;
        end
        ucv_pkg::ST_RX_TURN: begin
          s_nxt.oe_n     = 1'b0;
          s_nxt.dout     = {6'h00, s_r.ls_s[3:2]};
          s_nxt.dout[ucv_pkg::RXCMD_ALT_INT] = 1'b1;
          s_nxt.alt_pend = |ev;
          s_nxt.st       = ucv_pkg::ST_RX_DATA;
        end
        ucv_pkg::ST_RX_DATA: begin
          s_nxt.oe_n = 1'b1;
          s_nxt.dir  = 1'b0;
          s_nxt.st   = ucv_pkg::ST_IDLE;
        end
        default: begin
          s_nxt.st = ucv_pkg::ST_IDLE;
        end
      endcase
    end

    // Set wins over the read clear
    s_nxt.latch = s_nxt.latch | ev;
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_r          <= '0;
      s_r.st       <= ucv_pkg::ST_IDLE;
      s_r.latch    <= ucv_pkg::LATCH_RESET;
      s_r.comp_reg <= ucv_pkg::SIG_COMP_RESET;
      s_r.chg_reg  <= ucv_pkg::CHG_CTRL_RESET;
      s_r.oe_n     <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    ULPI_DATA_O                = s_r.dout;
    ULPI_DATA_OE_N_O           = s_r.oe_n;
    ULPI_DIR_O                 = s_r.dir;
    ULPI_NXT_O                 = s_r.nxt;
    SQUELCH_THRESHOLD_SELECT_O = s_r.comp_reg[ucv_pkg::SQ_LSB +: 2];
    TX_AMPLITUDE_BOOST_O       = s_r.comp_reg[ucv_pkg::BOOST_LSB +: 3];
    VSRC_DP_O    = s_r.chg_reg[ucv_pkg::CHG_VSRC] & ~host;
    VSRC_DM_O    = s_r.chg_reg[ucv_pkg::CHG_VSRC] & host;
    ISINK_DP_O   = s_r.chg_reg[ucv_pkg::CHG_ISINK] & ~host;
    ISINK_DM_O   = s_r.chg_reg[ucv_pkg::CHG_ISINK] & host;
    CONTACT_DP_O = s_r.chg_reg[ucv_pkg::CHG_CONTACT] & ~host;
    CONTACT_DM_O = s_r.chg_reg[ucv_pkg::CHG_CONTACT] & host;
    RESISTOR_CONV_COMPLETE_O = s_r.conv_done;
  end

endmodule // ucv_regs

// ===== tb/ucv_regs_properties.sv
`timescale 1ns/1ns
module ucv_regs_properties (
  // System
  input wire logic       MCLK_I,
  input wire logic       RST_I,
  // ULPI
  input wire logic [7:0] ULPI_DATA_O,
  input wire logic       ULPI_DATA_OE_N_O,
  input wire logic       ULPI_DIR_O,
  input wire logic       ULPI_NXT_O,
  // Controls
  input wire logic [1:0] SQUELCH_THRESHOLD_SELECT_O,
  input wire logic [2:0] TX_AMPLITUDE_BOOST_O,
  input wire logic       VSRC_DP_O,
  input wire logic       VSRC_DM_O,
  input wire logic       ISINK_DP_O,
  input wire logic       ISINK_DM_O,
  input wire logic       CONTACT_DP_O,
  input wire logic       CONTACT_DM_O,
  input wire logic       RESISTOR_CONV_START_I,
  input wire logic       RESISTOR_CONV_COMPLETE_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // Saturates so a missing start never wraps into a false match
  logic [12:0] cnt_r;
  always_ff @(posedge MCLK_I or posedge RST_I)
    if (RST_I) cnt_r <= 13'h0000;
    else if (RESISTOR_CONV_START_I) cnt_r <= 13'h0000;
    else if (cnt_r != 13'h1FFF) cnt_r <= cnt_r + 13'h0001;
  sequence rx_start;
    $rose(ULPI_DIR_O) && !$past(ULPI_NXT_O);
  endsequence
  sequence rx_byte;
    !ULPI_DATA_OE_N_O && ULPI_DATA_O[7:2] == 6'h20;
  endsequence
  a_rxcmd_form: assert property (rx_start |-> ##[6:10] rx_byte)
    else $error("status byte malformed or late");
  a_oe_needs_dir: assert property (!ULPI_DATA_OE_N_O |-> ULPI_DIR_O)
    else $error("data driven without bus ownership");
  a_nxt_not_dir: assert property (ULPI_NXT_O |-> !ULPI_DIR_O)
    else $error("accept flag while owning bus");
  a_data_window: assert property ($fell(ULPI_DATA_OE_N_O) |->
    (!ULPI_DATA_OE_N_O) [*8] ##1 ULPI_DATA_OE_N_O)
    else $error("driven byte not one link cycle");
  a_dpdm_swap: assert property ((VSRC_DP_O || ISINK_DP_O || CONTACT_DP_O)
    |-> !(VSRC_DM_O || ISINK_DM_O || CONTACT_DM_O))
    else $error("charger elements split across lines");
  a_reset_idle: assert property ($fell(RST_I) |-> !ULPI_DIR_O &&
    ULPI_DATA_OE_N_O && SQUELCH_THRESHOLD_SELECT_O == 2'h0 &&
    TX_AMPLITUDE_BOOST_O == 3'h0)
    else $error("outputs not idle after reset");
  a_conv_clear: assert property (RESISTOR_CONV_START_I |->
    ##[1:2] !RESISTOR_CONV_COMPLETE_O)
    else $error("done not cleared by start");
  a_conv_time: assert property ($rose(RESISTOR_CONV_COMPLETE_O) |->
    cnt_r >= 13'h0B00 && cnt_r <= 13'h0B08)
    else $error("conversion time wrong");
endmodule // ucv_regs_properties
bind ucv_regs ucv_regs_properties ucv_regs_properties_i (
  .MCLK_I(MCLK_I), .RST_I(RST_I), .ULPI_DATA_O(ULPI_DATA_O),
  .ULPI_DATA_OE_N_O(ULPI_DATA_OE_N_O), .ULPI_DIR_O(ULPI_DIR_O),
  .ULPI_NXT_O(ULPI_NXT_O),
  .SQUELCH_THRESHOLD_SELECT_O(SQUELCH_THRESHOLD_SELECT_O),
  .TX_AMPLITUDE_BOOST_O(TX_AMPLITUDE_BOOST_O), .VSRC_DP_O(VSRC_DP_O),
  .VSRC_DM_O(VSRC_DM_O), .ISINK_DP_O(ISINK_DP_O), .ISINK_DM_O(ISINK_DM_O),
  .CONTACT_DP_O(CONTACT_DP_O), .CONTACT_DM_O(CONTACT_DM_O),
  .RESISTOR_CONV_START_I(RESISTOR_CONV_START_I),
  .RESISTOR_CONV_COMPLETE_O(RESISTOR_CONV_COMPLETE_O));

// ===== tb/ucv_link.sv
`timescale 1ns/1ns
module ucv_link (
  // Clock
  input  wire logic       mclk_i,
  // Link side of the bus
  output logic            ulpi_clk_o,
  output logic      [7:0] ulpi_dout_o,
  output logic            ulpi_stp_o,
  input  wire logic [7:0] ulpi_din_i,
  input  wire logic       ulpi_oe_n_i,
  input  wire logic       ulpi_dir_i,
  input  wire logic       ulpi_nxt_i
);
  int alt_seen = 0;
  int nxt_miss = 0;
  initial begin
    ulpi_clk_o <= 1'b0;
    ulpi_dout_o <= 8'h00;
    ulpi_stp_o <= 1'b0;
  end
  // One 800 ns link cycle; bus values change on the falling edge
  task automatic step(input logic [7:0] d, input logic s);
    @(posedge mclk_i) ulpi_clk_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    ulpi_clk_o <= 1'b0;
    ulpi_dout_o <= d;
    ulpi_stp_o <= s;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    step({ucv_pkg::CMD_REG_WRITE, a}, 1'b0);
    step(d, 1'b0);
    if (ulpi_nxt_i !== 1'b1) nxt_miss++;
    step(d, 1'b0);
    step(8'h00, 1'b1);
    step(8'h00, 1'b0);
  endtask
  // Bus released by the link while the device owns it: inverse pattern
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    step({ucv_pkg::CMD_REG_READ, a}, 1'b0);
    step(~{ucv_pkg::CMD_REG_READ, a}, 1'b0);
    if (ulpi_nxt_i !== 1'b1) nxt_miss++;
    step({ucv_pkg::CMD_REG_READ, a}, 1'b0);
    step(~{ucv_pkg::CMD_REG_READ, a}, 1'b0);
    v = ulpi_din_i;
    step(8'h00, 1'b0);
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      step(8'h00, 1'b0);
      if (!ulpi_oe_n_i && ulpi_din_i[7]) alt_seen++;
    end
  endtask
endmodule // ucv_link

// ===== tb/ucv_regs_test.sv
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module ucv_regs_test;
  logic mclk = 1'b0, rst = 1'b1, idf = 1'b0, cdp = 1'b0, cdm = 1'b0;
  logic er = 1'b0, ef = 1'b0, ec = 1'b0, eres = 1'b0, go = 1'b0, done;
  logic [1:0] lst = 2'h0, sq;
  logic [2:0] boost;
  logic [5:0] pins;
  logic [7:0] dto, dti, v;
  logic oe_n, dir, uclk, stp, nxt;
  logic [3:0] id_tab [4] = '{4'hB, 4'h8, 4'h6, 4'h5};
  int err_total = 0, n_compared = 0;
  initial forever #50 mclk = ~mclk;
  ucv_link ucv_link_i (.mclk_i(mclk), .ulpi_clk_o(uclk), .ulpi_dout_o(dti),
    .ulpi_stp_o(stp), .ulpi_din_i(dto), .ulpi_oe_n_i(oe_n),
    .ulpi_dir_i(dir), .ulpi_nxt_i(nxt));
  ucv_regs ucv_regs_i (.MCLK_I(mclk), .RST_I(rst), .ULPI_CLK_I(uclk),
    .ULPI_DATA_I(dti), .ULPI_DATA_O(dto), .ULPI_DATA_OE_N_O(oe_n),
    .ULPI_DIR_O(dir), .ULPI_NXT_O(nxt), .ULPI_STP_I(stp), .ID_FLOAT_I(idf),
    .COMP_DP_I(cdp), .COMP_DM_I(cdm), .LINESTATE_I(lst),
    .ID_FLOAT_RISE_ENABLE_I(er), .ID_FLOAT_FALL_ENABLE_I(ef),
    .COMPARATOR_EVENT_ENABLE_I(ec), .RESISTOR_CONV_EVENT_ENABLE_I(eres),
    .RESISTOR_CONV_START_I(go), .SQUELCH_THRESHOLD_SELECT_O(sq),
    .TX_AMPLITUDE_BOOST_O(boost), .VSRC_DP_O(pins[5]),
    .VSRC_DM_O(pins[2]), .ISINK_DP_O(pins[4]), .ISINK_DM_O(pins[1]),
    .CONTACT_DP_O(pins[3]), .CONTACT_DM_O(pins[0]),
    .RESISTOR_CONV_COMPLETE_O(done));
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    ucv_link_i.rd(a, v);
    `CHK(v, e)
  endtask
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    rd_chk(ucv_pkg::ADDR_SIG_COMP, 8'h00);
    rd_chk(ucv_pkg::ADDR_CHG_DETECT, 8'h00);
    rd_chk(ucv_pkg::ADDR_EVENT_LATCH, 8'h00);
    $display("reset values done");
    for (int k = 0; k < 8; k++) begin
      ucv_link_i.wr(ucv_pkg::ADDR_SIG_COMP, {1'b1, 3'(k), 2'h3, 2'(k)});
      rd_chk(ucv_pkg::ADDR_SIG_COMP, {1'b0, 3'(k), 2'h0, 2'(k)});
      `CHK(sq, 2'(k))
      `CHK(boost, 3'(k))
    end
    ucv_link_i.wr(ucv_pkg::ADDR_EVENT_LATCH, 8'hFF);
    rd_chk(ucv_pkg::ADDR_EVENT_LATCH, 8'h00);
    ucv_link_i.wr(6'h3F, 8'hFF);
    rd_chk(6'h3F, 8'h00);
    rd_chk(6'h30, 8'h00);
    $display("compensation and refusals done");
    ucv_link_i.wr(ucv_pkg::ADDR_CHG_DETECT, 8'hF7);
    rd_chk(ucv_pkg::ADDR_CHG_DETECT, 8'h07);
    `CHK(pins, 6'h38)
    cdp <= 1'b1;
    rd_chk(ucv_pkg::ADDR_CHG_DETECT, 8'h17);
    lst <= 2'h1;
    rd_chk(ucv_pkg::ADDR_CHG_DETECT, 8'h07);
    lst <= 2'h0;
    ucv_link_i.wr(ucv_pkg::ADDR_CHG_DETECT, 8'h0D);
    rd_chk(ucv_pkg::ADDR_CHG_DETECT, 8'h0D);
    `CHK(pins, 6'h05)
    ucv_link_i.wr(ucv_pkg::ADDR_CHG_DETECT, 8'h0A);
    rd_chk(ucv_pkg::ADDR_CHG_DETECT, 8'h0A);
    cdm <= 1'b1;
    rd_chk(ucv_pkg::ADDR_CHG_DETECT, 8'h1A);
    rd_chk(ucv_pkg::ADDR_EVENT_LATCH, 8'h00);
    ec <= 1'b1;
    cdm <= 1'b0;
    ucv_link_i.idle(6);
    rd_chk(ucv_pkg::ADDR_EVENT_LATCH, 8'h02);
    rd_chk(ucv_pkg::ADDR_EVENT_LATCH, 8'h00);
    ucv_link_i.wr(ucv_pkg::ADDR_CHG_DETECT, 8'h00);
    $display("charger detection done");
    foreach (id_tab[k]) begin
      {er, ef} <= id_tab[k][3:2];
      @(posedge mclk) idf <= id_tab[k][1];
      ucv_link_i.idle(6);
      rd_chk(ucv_pkg::ADDR_EVENT_LATCH, {7'h00, id_tab[k][0]});
    end
    $display("id float events done");
    eres <= 1'b1;
    @(posedge mclk) go <= 1'b1;
    @(posedge mclk) go <= 1'b0;
    for (int k = 0; k < 4000 && done !== 1'b1; k++) @(posedge mclk);
    `CHK(done, 1'b1)
    if (done === 1'b1) begin
      ucv_link_i.idle(6);
      rd_chk(ucv_pkg::ADDR_EVENT_LATCH, 8'h08);
      `CHK(ucv_link_i.alt_seen, 4)
      // A new start must drop the done flag again
      @(posedge mclk) go <= 1'b1;
      @(posedge mclk) go <= 1'b0;
      @(posedge mclk);
      `CHK(done, 1'b0)
    end
    `CHK(ucv_link_i.nxt_miss, 0)
    $display("conversion event done");
    finish_test;
  end
endmodule // ucv_regs_test
